/* core/sic_cfg.svh */
// Register map, field positions, reset values and timing constants of the staged injection controller.
// Behaviour
// - Without full transfer, fully staged gives primaries and secondaries equal pulse widths; with gradual, secondaries keep the enrichment on top.
// - With full transfer, fully staged shuts primaries off; secondaries deliver all fuel.
// - Standard routing drives secondaries sequentially on A-H; only up to four cylinders.
// - Auxiliary routing batch-fires secondaries on channels I and J; required above four.
// - Alternating pattern fires I and J in turn, two pulses per engine cycle.
// - Simultaneous pattern fires I and J together, one pulse per engine cycle.
// - Gradual transition moves primary widths up or down toward their fully staged value and grows secondary widths progressively.
// - Without gradual transition widths jump to fully staged values on engagement.
// - Gradual transition takes the configured count of ignition events to complete.
// - Primary reduction waits a configured number of ignition events after secondaries start.
// - Gradual transition adds configured milliseconds of enrichment to secondary width.
// - Table staging disables gradual, enrichment, thresholds, hysteresis and second parameter.
// - Threshold modes engage when selected quantity reaches the primary threshold.
// - Staging disengages only when quantity falls to threshold minus hysteresis.
// - Second quantity has own threshold and hysteresis, ignored unless selected.
// - Combine setting chooses both conditions or either condition to engage.
// - Relay output asserted for secondaries when normal, deasserted when inverted.
// - Pre-relay goes active ahead of secondaries: on when normal, off when inverted.
// - Secondaries activate a configured number of seconds after the pre-relay.
// - Table value zero means unstaged, one hundred percent fully staged, between partial.
// - First parameter enables staging and selects off, speed, pressure, throttle, duty, table.
`ifndef SIC_CFG_SVH
`define SIC_CFG_SVH
// ==========================================================================
// Register offsets
`define SIC_ADDR_CTRL      8'h00
`define SIC_ADDR_THR1      8'h04
`define SIC_ADDR_THR2      8'h08
`define SIC_ADDR_TRANS     8'h0c
`define SIC_ADDR_ENRICH    8'h10
`define SIC_ADDR_PRERELAY  8'h14
`define SIC_ADDR_STATUS    8'h18
`define SIC_NUM_CFG        6
`define SIC_CFG_RESET      32'h0000_0000
// ==========================================================================
// Control register fields
`define SIC_F_FIRST_LSB    0
`define SIC_F_SECOND_LSB   4
`define SIC_F_COMBINE_AND  8
`define SIC_F_FULL_XFER    9
`define SIC_F_ROUTE_AUX    10
`define SIC_F_FIRE_SIMUL   11
`define SIC_F_GRADUAL      12
`define SIC_F_RELAY_INV    13
`define SIC_F_PRERELAY_INV 14
`define SIC_F_CYL_LSB      16
`define SIC_MAX_SEQ_CYL    4'h4
// ==========================================================================
// Scaling and timing
`define SIC_FULL_PCT       7'h64
`define SIC_US_PER_MS      10'h3e8
`define SIC_CLK_PERIOD_NS  25
`define SIC_NS_PER_S       1000000000
`define SIC_RESP_OKAY      2'h0
`define SIC_RESP_SLVERR    2'h2
`endif

/* core/sic_pkg.sv */
// Types shared by the staged injection controller.
package sic_pkg;
    // ======================================================================
    // Staging basis selection.
    typedef enum logic [2:0] {
        SIC_SEL_OFF   = 3'h0,
        SIC_SEL_RPM   = 3'h1,
        SIC_SEL_MAP   = 3'h2,
        SIC_SEL_THR   = 3'h3,
        SIC_SEL_DUTY  = 3'h4,
        SIC_SEL_TABLE = 3'h5
    } sic_sel_type;
    // ======================================================================
    // Relay sequencer states.
    typedef enum logic [2:0] {
        SIC_ST_IDLE    = 3'b001,
        SIC_ST_PREWAIT = 3'b010,
        SIC_ST_ACTIVE  = 3'b100
    } sic_state_type;
    typedef struct packed {
        logic [15:0] rpm;
        logic [15:0] map;
        logic [15:0] throttle_position;
        logic [15:0] primary_duty;
    } sic_sensor_type;
    typedef struct packed {
        logic [23:0] base;
        logic [23:0] full_equal;
        logic [23:0] full_sec;
    } sic_fuel_type;
    typedef struct packed {
        logic [23:0] pri;
        logic [23:0] sec;
    } sic_pw_type;
endpackage

/* core/sic_staged_injection_ctrl.sv */
// Staged injection controller with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "sic_cfg.svh"
module sic_staged_injection_ctrl
    import sic_pkg::*;
#(
    parameter int unsigned CYCLES_PER_SEC = `SIC_NS_PER_S / `SIC_CLK_PERIOD_NS
) (
    input  wire logic           aclk,
    input  wire logic           aresetn,
    input  wire logic [7:0]     s_axi_awaddr,
    input  wire logic           s_axi_awvalid,
    output logic                s_axi_awready,
    input  wire logic [31:0]    s_axi_wdata,
    input  wire logic [3:0]     s_axi_wstrb,
    input  wire logic           s_axi_wvalid,
    output logic                s_axi_wready,
    output logic [1:0]          s_axi_bresp,
    output logic                s_axi_bvalid,
    input  wire logic           s_axi_bready,
    input  wire logic [7:0]     s_axi_araddr,
    input  wire logic           s_axi_arvalid,
    output logic                s_axi_arready,
    output logic [31:0]         s_axi_rdata,
    output logic [1:0]          s_axi_rresp,
    output logic                s_axi_rvalid,
    input  wire logic           s_axi_rready,
    input  wire logic           ign_event_pin,
    input  wire logic           cycle_start_pin,
    input  wire sic_sensor_type sensors,
    input  wire logic [6:0]     table_pct,
    input  wire sic_fuel_type   fuel,
    output sic_pw_type          pw,
    output logic                sec_seq_en,
    output logic                aux_fire_i,
    output logic                aux_fire_j,
    output logic                relay_out,
    output logic                prerelay_out,
    output logic                staged
);
    // ======================================================================
    // Functions
    function automatic logic [31:0] apply_strobe(input logic [31:0] old, input logic [31:0] nw,
                                                 input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [15:0] select_quantity(input logic [2:0] sel, input sic_sensor_type s);
        logic [15:0] q;
        q = 16'h0000;
        case (sel)
            SIC_SEL_RPM:  q = s.rpm;
            SIC_SEL_MAP:  q = s.map;
            SIC_SEL_THR:  q = s.throttle_position;
            SIC_SEL_DUTY: q = s.primary_duty;
            default:      q = 16'h0000;
        endcase
        return q;
    endfunction

    // Threshold with hysteresis: engage at thr, release at or below thr - hyst.
    function automatic logic next_engaged(input logic cur, input logic [15:0] q,
                                          input logic [15:0] thr, input logic [15:0] hyst);
        logic [15:0] lo;
        lo = (thr > hyst) ? thr - hyst : 16'h0000;
        return cur ? (q > lo) : (q >= thr);
    endfunction

    function automatic int addr_index(input logic [7:0] a);
        return (a <= `SIC_ADDR_STATUS && a[1:0] == 2'h0) ? int'(a[7:2]) : -1;
    endfunction

    // ======================================================================
    // Register file and AXI4-Lite slave
    logic [31:0] cfg [`SIC_NUM_CFG];
    logic        aw_full;
    logic        w_full;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [31:0] status_word;
    logic [31:0] rd_word;
    wire         aw_take  = s_axi_awvalid && s_axi_awready;
    wire         w_take   = s_axi_wvalid && s_axi_wready;
    wire         wr_fire  = aw_full && w_full && !s_axi_bvalid;
    wire integer wr_idx   = addr_index(aw_addr);
    wire integer rd_idx   = addr_index(s_axi_araddr);
    wire         ar_take  = s_axi_arvalid && s_axi_arready;

    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready  = !w_full && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_word = (rd_idx == `SIC_NUM_CFG) ? status_word :
                     (rd_idx >= 0) ? cfg[rd_idx[2:0]] : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full <= 1'b0;
            end
            if (w_take) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SIC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_idx >= 0) ? `SIC_RESP_OKAY : `SIC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    for (genvar i = 0; i < `SIC_NUM_CFG; i++) begin : g_cfg
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cfg[i] <= `SIC_CFG_RESET;
            end else if (wr_fire && wr_idx == i) begin
                cfg[i] <= apply_strobe(cfg[i], w_data, w_strb);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `SIC_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= (rd_idx >= 0) ? `SIC_RESP_OKAY : `SIC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ======================================================================
    // Configuration decode
    wire [31:0]  ctrl       = cfg[0];
    wire [2:0]   first_sel  = ctrl[`SIC_F_FIRST_LSB +: 3];
    wire [2:0]   second_sel = ctrl[`SIC_F_SECOND_LSB +: 3];
    wire [3:0]   cyl_count  = ctrl[`SIC_F_CYL_LSB +: 4];
    wire         table_mode = (first_sel == SIC_SEL_TABLE);
    wire         second_on  = !table_mode && (select_quantity(second_sel, sensors) != 16'h0000 ||
                                               second_sel inside {[SIC_SEL_RPM:SIC_SEL_DUTY]});
    wire         gradual    = ctrl[`SIC_F_GRADUAL] && !table_mode;
    wire         full_xfer  = ctrl[`SIC_F_FULL_XFER];
    wire         aux_route  = ctrl[`SIC_F_ROUTE_AUX] || cyl_count > `SIC_MAX_SEQ_CYL;
    wire         fire_simul = ctrl[`SIC_F_FIRE_SIMUL];
    wire [15:0]  trans_evts = cfg[3][15:0];
    wire [15:0]  prim_delay = cfg[3][31:16];
    wire [7:0]   enrich_ms  = cfg[4][7:0];
    wire [7:0]   pre_secs   = cfg[5][7:0];

    // ======================================================================
    // Pin synchronisers and event detection
    logic [2:0] ign_sync;
    logic [2:0] cyc_sync;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ign_sync <= 3'h0;
            cyc_sync <= 3'h0;
        end else begin
            ign_sync <= {ign_sync[1:0], ign_event_pin};
            cyc_sync <= {cyc_sync[1:0], cycle_start_pin};
        end
    end
    wire ign_ev = ign_sync[1] && !ign_sync[2];
    wire cyc_ev = cyc_sync[1] && !cyc_sync[2];

    // ======================================================================
    // Threshold engagement, evaluated once per ignition event
    logic eng1;
    logic eng2;
    wire  [15:0] q1 = select_quantity(first_sel, sensors);
    wire  [15:0] q2 = select_quantity(second_sel, sensors);
    wire  cond_comb = !second_on ? eng1 :
                      ctrl[`SIC_F_COMBINE_AND] ? (eng1 && eng2) : (eng1 || eng2);
    wire  engage_req = table_mode ? (table_pct != 7'h00) :
                       (first_sel != SIC_SEL_OFF) && cond_comb;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eng1 <= 1'b0;
            eng2 <= 1'b0;
        end else if (first_sel == SIC_SEL_OFF || table_mode) begin
            eng1 <= 1'b0;
            eng2 <= 1'b0;
        end else if (ign_ev) begin
            eng1 <= next_engaged(eng1, q1, cfg[1][15:0], cfg[1][31:16]);
            eng2 <= second_on && next_engaged(eng2, q2, cfg[2][15:0], cfg[2][31:16]);
        end
    end

    // ======================================================================
    // Pre-relay and relay sequencer
    sic_state_type state;
    sic_state_type next_state;
    logic [31:0]   presc;
    logic [7:0]    sec_cnt;
    wire           sec_tick = (presc == CYCLES_PER_SEC - 1);
    wire           pre_done = (sec_cnt >= pre_secs);
    wire           stage_on = (state == SIC_ST_ACTIVE);

    always_comb begin
        next_state = state;
        unique case (state)
            SIC_ST_IDLE:    if (engage_req) next_state = (pre_secs == 8'h00) ? SIC_ST_ACTIVE : SIC_ST_PREWAIT;
            SIC_ST_PREWAIT: if (!engage_req) next_state = SIC_ST_IDLE;
                            else if (pre_done) next_state = SIC_ST_ACTIVE;
            SIC_ST_ACTIVE:  if (!engage_req) next_state = SIC_ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state   <= SIC_ST_IDLE;
            presc   <= 32'h0000_0000;
            sec_cnt <= 8'h00;
        end else begin
            state <= next_state;
            if (state != SIC_ST_PREWAIT) begin
                presc   <= 32'h0000_0000;
                sec_cnt <= 8'h00;
            end else if (sec_tick) begin
                presc   <= 32'h0000_0000;
                sec_cnt <= sec_cnt + 8'h01;
            end else begin
                presc <= presc + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            relay_out    <= 1'b0;
            prerelay_out <= 1'b0;
            staged       <= 1'b0;
        end else begin
            relay_out    <= stage_on ^ ctrl[`SIC_F_RELAY_INV];
            prerelay_out <= (state != SIC_ST_IDLE) ^ ctrl[`SIC_F_PRERELAY_INV];
            staged       <= stage_on;
        end
    end

    // ======================================================================
    // Staging fractions: channel 0 secondary, channel 1 primary
    logic [6:0]  frac [2];
    logic [16:0] acc  [2];
    logic [15:0] dly_cnt;
    wire         dly_done = (dly_cnt >= prim_delay);
    wire  [6:0]  tbl_clip = (table_pct > `SIC_FULL_PCT) ? `SIC_FULL_PCT : table_pct;

    always_ff @(posedge aclk) begin
        if (!aresetn || !stage_on || !gradual) begin
            dly_cnt <= 16'h0000;
        end else if (ign_ev && !dly_done) begin
            dly_cnt <= dly_cnt + 16'h0001;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_ramp
        wire        run   = (g == 0) || dly_done;
        wire        full  = (frac[g] == `SIC_FULL_PCT);
        wire        add   = ign_ev && run && !full;
        wire        drain = (acc[g] >= {1'b0, trans_evts}) && !full;
        wire [16:0] acc_n = acc[g] + (add ? 17'd100 : 17'd0) - (drain ? {1'b0, trans_evts} : 17'd0);
        always_ff @(posedge aclk) begin
            if (!aresetn || !stage_on) begin
                frac[g] <= 7'h00;
                acc[g]  <= 17'h00000;
            end else if (table_mode) begin
                frac[g] <= tbl_clip;
            end else if (!gradual || trans_evts == 16'h0000) begin
                frac[g] <= `SIC_FULL_PCT;
            end else begin
                acc[g] <= acc_n;
                if (drain) begin
                    frac[g] <= frac[g] + 7'h01;
                end
            end
        end
    end

    // ======================================================================
    // Pulse width computation
    wire [23:0] pri_full = full_xfer ? 24'h000000 : fuel.full_equal;
    wire [23:0] sec_full = full_xfer ? fuel.full_sec : fuel.full_equal;
    // The primary moves toward its fully staged width from above or below.
    wire        pri_up   = (fuel.base < pri_full);
    wire [23:0] pri_gap  = pri_up ? pri_full - fuel.base : fuel.base - pri_full;
    wire [30:0] pri_prod = pri_gap * frac[1];
    wire [30:0] sec_prod = sec_full * frac[0];
    wire [23:0] enrich   = (gradual && stage_on) ? 24'(enrich_ms * `SIC_US_PER_MS) : 24'h000000;
    wire [23:0] pri_step = 24'(pri_prod / 31'd100);
    wire [23:0] next_pri = pri_up ? fuel.base + pri_step : fuel.base - pri_step;
    wire [23:0] next_sec = stage_on ? 24'(sec_prod / 31'd100) + enrich : 24'h000000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pw <= '0;
        end else begin
            pw.pri <= next_pri;
            pw.sec <= next_sec;
        end
    end

    // ======================================================================
    // Secondary output routing
    logic [3:0] ev_idx;
    wire  [3:0] idx_eff = cyc_ev ? 4'h0 : ev_idx;
    wire        fire_on = stage_on && aux_route && ign_ev;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_idx     <= 4'h0;
            aux_fire_i <= 1'b0;
            aux_fire_j <= 1'b0;
            sec_seq_en <= 1'b0;
        end else begin
            if (ign_ev) begin
                ev_idx <= idx_eff + 4'h1;
            end else if (cyc_ev) begin
                ev_idx <= 4'h0;
            end
            aux_fire_i <= fire_on && idx_eff == 4'h0;
            aux_fire_j <= fire_on && (fire_simul ? idx_eff == 4'h0 : idx_eff == (cyl_count >> 1));
            sec_seq_en <= stage_on && !aux_route;
        end
    end

    assign status_word = {10'h000, frac[1], 1'b0, frac[0], 1'b0, state, eng2, eng1, staged};

    // ======================================================================
    // Assertions
    AST_EQUAL_WIDTHS: assert property (@(posedge aclk) disable iff (!aresetn)
        (stage_on && frac[0] == 7'd100 && frac[1] == 7'd100 && !full_xfer && !gradual && !table_mode)
        |=> pw.pri == pw.sec) else $error("fully staged widths differ");
    AST_FULL_XFER: assert property (@(posedge aclk) disable iff (!aresetn)
        (frac[1] == 7'd100 && full_xfer && fuel.base >= fuel.full_equal) |=> pw.pri == 24'h000000)
        else $error("primary not shut off under full transfer");
    AST_SEQ_ROUTE: assert property (@(posedge aclk) disable iff (!aresetn)
        sec_seq_en |-> $past(cyl_count <= `SIC_MAX_SEQ_CYL && stage_on)) else $error("sequential route misused");
    AST_AUX_ALT: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(!fire_simul && cyl_count > 4'h1) && aux_fire_i) |-> !aux_fire_j) else $error("alternating overlap");
    AST_AUX_SIM: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(fire_simul) |-> aux_fire_i == aux_fire_j) else $error("simultaneous pulses differ");
    AST_STEP_ON: assert property (@(posedge aclk) disable iff (!aresetn)
        (stage_on && !gradual && !table_mode) ##1 (stage_on && !gradual && !table_mode) |-> frac[0] == 7'd100)
        else $error("no immediate staging");
    AST_LINEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        (stage_on && $past(stage_on) && gradual && $past(gradual) && !table_mode && trans_evts != 16'h0000
         && frac[0] != $past(frac[0]))
        |-> frac[0] == $past(frac[0]) + 7'd1) else $error("fraction jumped");
    AST_PRI_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
        (stage_on && gradual && trans_evts != 16'h0000 && !dly_done) |=> frac[1] == 7'h00 || !$past(stage_on))
        else $error("primary cut early");
    AST_ENGAGE: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(eng1) |-> $past(ign_ev && q1 >= cfg[1][15:0])) else $error("engaged without threshold");
    AST_RELAY: assert property (@(posedge aclk) disable iff (!aresetn)
        stage_on |=> relay_out == !ctrl[`SIC_F_RELAY_INV] || $changed(ctrl)) else $error("relay level wrong");
    AST_PREWAIT: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == SIC_ST_PREWAIT && !pre_done) |=> state != SIC_ST_ACTIVE) else $error("secondaries too soon");
    COV_GRADUAL: cover property (@(posedge aclk) disable iff (!aresetn) gradual && stage_on && frac[0] == 7'd100);
    COV_PREWAIT: cover property (@(posedge aclk) disable iff (!aresetn) state == SIC_ST_PREWAIT ##1 stage_on);
    COV_AUX_J:   cover property (@(posedge aclk) disable iff (!aresetn) aux_fire_j && !aux_fire_i);
endmodule // sic_staged_injection_ctrl

/* verification/sic_engine_model.sv */
// Engine side model giving ignition events and cycle start markers.
`timescale 1ns/1ps
module sic_engine_model (
    input  wire logic aclk,
    output logic      ign_event_pin,
    output logic      cycle_start_pin
);
    initial begin
        ign_event_pin = 1'b0;
        cycle_start_pin = 1'b0;
    end
    // Each pulse stays high two cycles and low gap cycles, so the synchroniser sees every edge.
    task automatic fire(input int gap, input logic start);
        @(posedge aclk);
        ign_event_pin <= !start;
        cycle_start_pin <= start;
        repeat (2) @(posedge aclk);
        ign_event_pin <= 1'b0;
        cycle_start_pin <= 1'b0;
        repeat (gap) @(posedge aclk);
    endtask
endmodule // sic_engine_model

/* verification/sic_testbench.sv */
// Self-checking bench for the staged injection controller.
`timescale 1ns/1ps
`include "sic_cfg.svh"
module testbench;
    import sic_pkg::*;
    logic           aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]     s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]    s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]     s_axi_wstrb = 4'hf;
    logic           s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic           s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]     s_axi_bresp, s_axi_rresp;
    logic           ign_event_pin, cycle_start_pin, sec_seq_en, aux_fire_i, aux_fire_j;
    logic           relay_out, prerelay_out, staged;
    sic_sensor_type sensors = '0;
    logic [6:0]     table_pct = 7'h00;
    sic_fuel_type   fuel = '0;
    sic_pw_type     pw;
    int             checks = 0, fail_count = 0, seed = 32'h58a2, n_fire = 0;
    logic [33:0]    q[$];
    initial forever #12.5 aclk = ~aclk;
    sic_staged_injection_ctrl #(.CYCLES_PER_SEC(20)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ign_event_pin, .cycle_start_pin, .sensors, .table_pct, .fuel, .pw, .sec_seq_en,
        .aux_fire_i, .aux_fire_j, .relay_out, .prerelay_out, .staged);
    sic_engine_model i_eng (.aclk, .ign_event_pin, .cycle_start_pin);
    // ======================================================================
    // Helpers
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        q.push_back({r, w ? 32'h0 : d});
        @(posedge aclk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_bvalid || s_axi_rvalid));
        {s_axi_bready, s_axi_rready} <= 2'b00;
    endtask
    task automatic ev(input int n, input int gap);
        repeat (n) i_eng.fire(gap, 1'b0);
        #1;
    endtask
    task automatic step(input logic [15:0] v);
        @(posedge aclk);
        sensors.rpm <= v;
        ev(1, 6);
    endtask
    task automatic end_of_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) chk("bresp", q.pop_front(), {s_axi_bresp, 32'h0});
        if (s_axi_rvalid && s_axi_rready) chk("rdata", q.pop_front(), {s_axi_rresp, s_axi_rdata});
        n_fire = n_fire + 100 * aux_fire_i + 10 * aux_fire_j + (aux_fire_i & aux_fire_j);
    end
    // ======================================================================
    // Scenarios
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        fuel <= {24'($random(seed)), 24'($random(seed)), 24'($random(seed))};
        axi(0, `SIC_ADDR_CTRL, 32'h0, 2'h0);
        axi(0, 8'h1c, 32'h0, `SIC_RESP_SLVERR);
        axi(1, 8'h1c, 32'h0, `SIC_RESP_SLVERR);
        axi(1, `SIC_ADDR_THR1, 32'h001e_0064, 2'h0);
        axi(0, `SIC_ADDR_THR1, 32'h001e_0064, 2'h0);
        axi(1, `SIC_ADDR_CTRL, 32'h1, 2'h0);
        step(16'h0063);
        chk("staged", 34'(staged), 34'h0);
        step(16'h0064);
        chk("staged", 34'({staged, relay_out, sec_seq_en}), 34'h7);
        chk("pri", 34'(pw.pri), 34'(fuel.full_equal));
        chk("sec", 34'(pw.sec), 34'(fuel.full_equal));
        step(16'h0047);
        chk("staged", 34'(staged), 34'h1);
        step(16'h0046);
        chk("staged", 34'(staged), 34'h0);
        chk("pri", 34'(pw.pri), 34'(fuel.base));
        $display("test threshold done");
        axi(1, `SIC_ADDR_CTRL, 32'h201, 2'h0);
        step(16'h0064 + 16'({$random(seed)} % 900));
        chk("pri", 34'(pw.pri), 34'h0);
        chk("sec", 34'(pw.sec), 34'(fuel.full_sec));
        for (int k = 0; k < 2; k++) begin
            axi(1, `SIC_ADDR_CTRL, 32'h0004_0401 | (k << 11), 2'h0);
            i_eng.fire(6, 1'b1);
            #1;
            n_fire = 0;
            ev(4, 6);
            chk("seq", 34'(sec_seq_en), 34'h0);
            chk("fires", 34'(n_fire), 34'(110 + k));
        end
        $display("test routing done");
        step(16'h0000);
        axi(1, `SIC_ADDR_PRERELAY, 32'h1, 2'h0);
        axi(1, `SIC_ADDR_CTRL, 32'h6001, 2'h0);
        step(16'h0064);
        chk("relays", 34'({prerelay_out, relay_out, staged}), 34'h2);
        repeat (20) @(posedge aclk);
        #1;
        chk("relays", 34'({prerelay_out, relay_out, staged}), 34'h1);
        $display("test relays done");
        step(16'h0000);
        axi(1, `SIC_ADDR_PRERELAY, 32'h0, 2'h0);
        axi(1, `SIC_ADDR_TRANS, 32'h0001_0004, 2'h0);
        axi(1, `SIC_ADDR_ENRICH, 32'h0000_0001, 2'h0);
        axi(1, `SIC_ADDR_CTRL, 32'h1001, 2'h0);
        step(16'h0064);
        chk("ramp", 34'(pw.sec), 34'(`SIC_US_PER_MS));
        ev(1, 30);
        chk("pri", 34'(pw.pri), 34'(fuel.base));
        ev(3, 30);
        chk("sec", 34'(pw.sec), 34'(fuel.full_equal + 24'(`SIC_US_PER_MS)));
        ev(1, 30);
        chk("pri", 34'(pw.pri), 34'(fuel.full_equal));
        $display("test gradual done");
        @(posedge aclk);
        table_pct <= 7'h7f;
        axi(1, `SIC_ADDR_CTRL, 32'h1005, 2'h0);
        repeat (3) @(posedge aclk);
        #1;
        chk("sec", 34'(pw.sec), 34'(fuel.full_equal));
        @(posedge aclk);
        table_pct <= 7'h00;
        repeat (3) @(posedge aclk);
        #1;
        chk("staged", 34'(staged), 34'h0);
        $display("test table done");
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge aclk);
        fail_count++;
        end_of_test();
    end
endmodule // testbench
